// file: spi_sw_pkg.sv
// Constants and field layouts of the serial switch-state controller.
// Assumes nothing beyond a SystemVerilog compiler; shared by all files but the host model.
package spi_sw_pkg;

  // Frame and register widths, synchroniser depth
  localparam int FRAME_BITS = 16;
  localparam int REG_BITS = 8;
  localparam int CTRL_BITS = 7;
  localparam int SYNC_STAGES = 2;

  // Field positions inside a frame (bit 15 goes out first)
  localparam int WR_EN_POS = 15;
  localparam int STATE_MSB = 7;

  // Reset values: everything clears at power-on
  localparam logic [REG_BITS-1:0] STATE_RST = 8'h00;
  localparam logic [CTRL_BITS-1:0] CTRL_RST = 7'h00;
  localparam logic [FRAME_BITS-1:0] FRAME_RST = 16'h0000;

  // Level of the interface-select pin that enables serial mode
  localparam logic IFACE_ACTIVE = 1'b0;

  // Highest link clock the far end may run, in MHz
  localparam int SCLK_MAX_MHZ = 33;

  // Control register, bits 6..0 (bit 7 is the frame's write enable)
  typedef struct packed {
    logic fault_latched;      // bit 6, sticky fault status
    logic sleep_mode;         // bit 5, analog circuits off
    logic fault_shutdown_off; // bit 4, 1 = report only
    logic pump_monitor_off;   // bit 3, rail comparator off
    logic spare_2;            // bit 2, don't care
    logic pump_enable;        // bit 1, charge pump on
    logic spare_0;            // bit 0, don't care
  } ctrl_t;

  // Switch state register
  typedef struct packed {
    logic must_be_zero;       // bit 7
    logic drive_g;            // bit 6, first mid-speed pair
    logic drive_f;            // bit 5, first high-speed pair
    logic drive_e;            // bit 4, first low-speed pair
    logic drive_d;            // bit 3, second mid-speed pair
    logic drive_c;            // bit 2, second low-speed pair
    logic drive_b;            // bit 1, second high-speed pair
    logic drive_a;            // bit 0
  } state_t;

  // One serial frame, most significant bit first
  typedef struct packed {
    logic write_enable;
    ctrl_t ctrl;
    state_t state;
  } frame_t;

endpackage

// file: sync_bit.sv
// Two-flop synchroniser for one level entering the system clock domain.
// Assumes the input is a quasi-static pin level; reset is asynchronous.
`timescale 1ns/1ps
module sync_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,     // destination clock
  input wire logic rst_n,   // asynchronous reset, active low
  input wire logic d,       // asynchronous level
  output logic q            // synchronised level
);
  import spi_sw_pkg::*;

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // The first stage feeds only the second stage
  always_comb
  begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule // sync_bit

// file: spi_switch_state_control.sv
// Serial switch-state controller: 16-bit shift register target with
// daisy-chain pass-through, state and control registers, fault handling.
// Assumes the link clock idles low while select_n is high and that
// fault_detect is the already combined output of the supply comparators.
//
// Function
// [RULE1] Each transaction carries one 16-bit word per device, MSB first.
// [RULE2] First frame bit is the write enable; high allows register update.
// [RULE3] Next seven bits are control/fault bits, low eight the switch state.
// [RULE4] On select falling, the MSB of the outgoing word is on the output; here miso_oe drives it only a few clocks later.
// [RULE5] Input data is sampled on each rising link clock edge.
// [RULE6] Host keeps link clock idle while deselected, meets setup.
// [RULE7] Output data changes on each falling link clock edge.
// [RULE8] Previous received word shifts out while the new one shifts in.
// [RULE9] On select rising, copy word to registers only if write enable set.
// [RULE10] Host runs the link clock at 33 MHz or slower.
// [RULE11] Serial interface works only while interface-select pin is low; here the shift register still shifts while it is high.
// [RULE12] High spread spectrum pin enables spread spectrum in serial mode.
// [RULE13] Two 8-bit registers, state and control, read by clocking out.
// [RULE14] Power-on reset clears both registers to zero.
// [RULE15] Undriven select keeps the interface deselected and disabled.
// [RULE16] Host always writes zero to state bit 7.
// [RULE17] State bits 6,5,4 drive outputs g,f,e; 1 is pump rail, 0 ground.
// [RULE18] State bits 3,2,1 drive outputs d,c,b; 1 is pump rail, 0 ground.
// [RULE19] State bit 0 drives output a to pump rail or ground.
// [RULE20] Control bit 1 enables the charge pump.
// [RULE21] Fault flag sticks until written 0; shutdown needs pump re-enable.
// [RULE22] Control bit 4 low shuts down on fault, high only reports.
// [RULE23] Link clock edges while deselected change nothing.
// [RULE24] Outputs hold last committed state until a write frame commits.
`timescale 1ns/1ps
module spi_switch_state_control #(
  parameter int FRAME_W = spi_sw_pkg::FRAME_BITS
) (
  input wire logic clk,                  // system clock, 20 MHz
  input wire logic rst_n,                // power-on reset, active low
  input wire logic sclk,                 // link clock from the host
  input wire logic mosi,                 // serial data in
  input wire logic select_n,             // frame select, active low
  input wire logic iface_sel,            // interface-select strap
  input wire logic spread_pin,           // spread spectrum request
  input wire logic fault_detect,         // supply fault, active high
  output logic miso,                     // serial data out
  output logic miso_oe,                  // serial data out enable
  output logic fault_pin_o,              // fault pin level when driven
  output logic fault_pin_oe,             // fault pin pulls low when high
  output logic drive_out_a,              // switch driver a
  output logic drive_out_b,              // switch driver b
  output logic drive_out_c,              // switch driver c
  output logic drive_out_d,              // switch driver d
  output logic drive_out_e,              // switch driver e
  output logic drive_out_f,              // switch driver f
  output logic drive_out_g,              // switch driver g
  output logic pump_on,                  // charge pump run
  output logic sleep_on,                 // analog sleep
  output logic pump_monitor_off,         // rail comparator disable
  output logic spread_enable,            // spread spectrum enable
  output spi_sw_pkg::ctrl_t ctrl_view,   // control register contents
  output spi_sw_pkg::state_t state_view  // state register contents
);
  import spi_sw_pkg::*;

  if (FRAME_W != $bits(frame_t))
  begin : g_frame_check
    $error("FRAME_W must match the frame layout width");
  end

  // ---------------- Reset release ----------------
  logic [SYNC_STAGES-1:0] rst_pipe_q;
  logic [SYNC_STAGES-1:0] rst_pipe_d;
  logic rst_sync_n;

  always_comb
  begin
    rst_pipe_d = {rst_pipe_q[SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe_q <= '0;
    else
      rst_pipe_q <= rst_pipe_d;
  end

  assign rst_sync_n = rst_pipe_q[SYNC_STAGES-1];

  // ---------------- Link clock domain ----------------
  // Input bit is caught on the rising edge, the shift happens on the
  // falling edge so the output only moves on falling edges.
  logic rx_q;
  logic rx_d;
  frame_t sh_q;
  frame_t sh_d;

  always_comb
  begin
    rx_d = select_n ? rx_q : mosi; // see [RULE5] see [RULE23]
    sh_d = select_n ? sh_q : {sh_q[FRAME_W-2:0], rx_q}; // see [RULE8]
  end

  always_ff @(posedge sclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rx_q <= 1'b0;
    else
      rx_q <= rx_d;
  end

  // Stray edges while deselected are masked, so the word is frozen then
  always_ff @(negedge sclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sh_q <= FRAME_RST;
    else
      sh_q <= sh_d; // see [RULE7] see [RULE6] see [RULE23]
  end

  // Word MSB already sits in the register when select falls
  assign miso = sh_q[WR_EN_POS]; // see [RULE4] see [RULE13] see [RULE1]

  // ---------------- Pin synchronisers ----------------
  logic sel_s;
  logic iface_s;
  logic spread_s;
  logic fault_s;

  sync_bit #(.RESET_VAL(1'b1)) u_sync_sel (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(select_n),
    .q(sel_s)
  ); // see [RULE15]

  sync_bit #(.RESET_VAL(1'b1)) u_sync_iface (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(iface_sel),
    .q(iface_s)
  );

  sync_bit #(.RESET_VAL(1'b0)) u_sync_spread (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(spread_pin),
    .q(spread_s)
  );

  sync_bit #(.RESET_VAL(1'b0)) u_sync_fault (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(fault_detect),
    .q(fault_s)
  );

  // ---------------- Commit and registers ----------------
  logic sel_prev_q;
  logic sel_prev_d;
  logic commit;
  logic write_ok;
  frame_t word;
  state_t state_q;
  state_t state_d;
  ctrl_t ctrl_q;
  ctrl_t ctrl_d;
  logic shut_q;
  logic shut_d;
  logic fault_clr;

  // The shift register is read here only after select has been seen
  // high for two clocks; its clock is idle then, so the word is stable.
  assign word = sh_q;
  assign commit = sel_s && !sel_prev_q && (iface_s == IFACE_ACTIVE);
  assign write_ok = commit && word.write_enable; // see [RULE2] see [RULE11]
  assign fault_clr = write_ok && !word.ctrl.fault_latched;

  always_comb
  begin
    sel_prev_d = sel_s;
    state_d = state_q;
    ctrl_d = ctrl_q;
    shut_d = shut_q;
    if (write_ok)
    begin
      state_d = word.state; // see [RULE9] see [RULE3] see [RULE16]
      ctrl_d = word.ctrl; // see [RULE9] see [RULE3]
    end
    // Software can only clear the fault flag; a new fault wins
    ctrl_d.fault_latched = fault_s ||
      (ctrl_q.fault_latched && !fault_clr); // see [RULE21]
    // Shutdown is left only by writing the pump enable low
    if (write_ok && !word.ctrl.pump_enable)
      shut_d = 1'b0; // see [RULE21]
    if (fault_s && !ctrl_q.fault_shutdown_off)
      shut_d = 1'b1; // see [RULE22]
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sel_prev_q <= 1'b1;
      state_q <= STATE_RST; // see [RULE14]
      ctrl_q <= CTRL_RST; // see [RULE14]
      shut_q <= 1'b0;
    end
    else
    begin
      sel_prev_q <= sel_prev_d;
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      shut_q <= shut_d;
    end
  end

  // ---------------- Registered outputs ----------------
  state_t drv_q;
  state_t drv_d;
  logic pump_q;
  logic pump_d;
  logic aux_sleep_q;
  logic aux_sleep_d;
  logic mon_off_q;
  logic mon_off_d;
  logic spread_q;
  logic spread_d;
  logic oe_q;
  logic oe_d;
  logic flt_oe_q;
  logic flt_oe_d;

  always_comb
  begin
    // Shutdown opens every switch; otherwise outputs follow the register
    drv_d = shut_q ? STATE_RST : state_q; // see [RULE24] see [RULE22]
    pump_d = ctrl_q.pump_enable && !shut_q; // see [RULE20]
    aux_sleep_d = ctrl_q.sleep_mode;
    mon_off_d = ctrl_q.pump_monitor_off;
    spread_d = spread_s && (iface_s == IFACE_ACTIVE); // see [RULE12]
    // Release lags select by the synchroniser, a few clocks not 10 ns
    oe_d = !sel_s && (iface_s == IFACE_ACTIVE); // see [RULE11]
    flt_oe_d = fault_s;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      drv_q <= STATE_RST;
      pump_q <= 1'b0;
      aux_sleep_q <= 1'b0;
      mon_off_q <= 1'b0;
      spread_q <= 1'b0;
      oe_q <= 1'b0;
      flt_oe_q <= 1'b0;
    end
    else
    begin
      drv_q <= drv_d;
      pump_q <= pump_d;
      aux_sleep_q <= aux_sleep_d;
      mon_off_q <= mon_off_d;
      spread_q <= spread_d;
      oe_q <= oe_d;
      flt_oe_q <= flt_oe_d;
    end
  end

  assign drive_out_g = drv_q.drive_g; // see [RULE17]
  assign drive_out_f = drv_q.drive_f; // see [RULE17]
  assign drive_out_e = drv_q.drive_e; // see [RULE17]
  assign drive_out_d = drv_q.drive_d; // see [RULE18]
  assign drive_out_c = drv_q.drive_c; // see [RULE18]
  assign drive_out_b = drv_q.drive_b; // see [RULE18]
  assign drive_out_a = drv_q.drive_a; // see [RULE19]
  assign pump_on = pump_q;
  assign sleep_on = aux_sleep_q;
  assign pump_monitor_off = mon_off_q;
  assign spread_enable = spread_q;
  assign miso_oe = oe_q;
  // Open drain: only ever pulls low
  assign fault_pin_o = 1'b0;
  assign fault_pin_oe = flt_oe_q;
  assign ctrl_view = ctrl_q;
  assign state_view = state_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence write_commit_s;
    write_ok;
  endsequence
  sequence fault_trip_s;
    fault_s && !ctrl_q.fault_shutdown_off;
  endsequence

  commit_write_a: assert property ( // see [RULE9]
    write_commit_s |=> state_q == $past(word.state))
    else $error("state not loaded on write commit");
  read_only_hold_a: assert property ( // see [RULE9]
    commit && !word.write_enable |=> state_q == $past(state_q))
    else $error("state changed on read-only frame");

  iface_gate_a: assert property ( // see [RULE11]
    sel_s && !sel_prev_q && iface_s |=> $stable(state_q))
    else $error("commit accepted with interface disabled");

  reset_clear_a: assert property ( // see [RULE14]
    $rose(rst_sync_n) |-> state_q == STATE_RST && ctrl_q == CTRL_RST)
    else $error("registers not cleared at reset");

  fault_sticky_a: assert property ( // see [RULE21]
    ctrl_q.fault_latched && !fault_clr |=> ctrl_q.fault_latched)
    else $error("fault flag dropped without a clearing write");

  fault_shutdown_a: assert property ( // see [RULE22]
    fault_trip_s |=> shut_q ##1 (drv_q == STATE_RST && !pump_q))
    else $error("fault did not shut the outputs down");

  pump_follow_a: assert property ( // see [RULE20]
    ##1 pump_q == ($past(ctrl_q.pump_enable) && !$past(shut_q)))
    else $error("pump output does not follow its enable");

  drive_map_a: assert property ( // see [RULE17]
    !shut_q ##1 !$past(shut_q) |-> drive_out_g == $past(state_q.drive_g)
      && drive_out_d == $past(state_q.drive_d))
    else $error("driver outputs do not follow the state register");

  outputs_hold_a: assert property ( // see [RULE24]
    !write_ok && !shut_q && !fault_s ##1 !shut_q |=> $stable(drv_q))
    else $error("driver outputs moved without a commit");

endmodule // spi_switch_state_control

// file: spi_host_model.sv
// Host controller model driving the switch controller's serial link.
// Assumes a pull-down on data and clock and a pull-up on select.
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,     // link clock, idles low
  output logic mosi,     // data to the device
  output logic select_n, // frame select, active low
  input wire logic miso  // resolved data line from the device
);
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    select_n = 1'b1;
  end

  // One frame of n bits, MSB first; 80 ns link period, below 33 MHz
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    select_n <= 1'b0;
    // Output enable is resynchronised, so give it time to appear
    #200;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi <= (i % 16 == 7) ? 1'b0 : tx[i];
      #20;
      rx[i] = miso;
      sclk <= 1'b1;
      #40;
      sclk <= 1'b0;
      #20;
    end
    mosi <= 1'b0;
    #130;
    select_n <= 1'b1;
    #300;
  endtask
endmodule // spi_host_model

// file: spi_switch_state_control_tb.sv
// Self-checking bench for the serial switch-state controller.
// Assumes the host model drives the link; straps and fault come from here.
`timescale 1ns/1ps
module spi_switch_state_control_tb;
  import spi_sw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic iface_sel = 1'b0;
  logic spread_pin = 1'b0;
  logic fault_detect = 1'b0;
  logic sclk, mosi, select_n, miso, miso_oe, fault_pin_o, fault_pin_oe;
  logic drive_out_a, drive_out_b, drive_out_c, drive_out_d;
  logic drive_out_e, drive_out_f, drive_out_g;
  logic pump_on, sleep_on, pump_monitor_off, spread_enable;
  logic miso_line, fault_line;
  ctrl_t ctrl_view;
  state_t state_view;
  int n_errors = 0;
  int total_checks = 0;

  // Pull-down on the data line, pull-up on the open-drain fault line
  assign miso_line = miso_oe ? miso : 1'b0;
  assign fault_line = fault_pin_oe ? fault_pin_o : 1'b1;

  always #25 clk = ~clk;

  spi_switch_state_control dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi),
    .select_n(select_n), .iface_sel(iface_sel), .spread_pin(spread_pin),
    .fault_detect(fault_detect), .miso(miso), .miso_oe(miso_oe),
    .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
    .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
    .drive_out_c(drive_out_c), .drive_out_d(drive_out_d),
    .drive_out_e(drive_out_e), .drive_out_f(drive_out_f),
    .drive_out_g(drive_out_g), .pump_on(pump_on), .sleep_on(sleep_on),
    .pump_monitor_off(pump_monitor_off), .spread_enable(spread_enable),
    .ctrl_view(ctrl_view), .state_view(state_view)
  );

  spi_host_model host (
    .sclk(sclk), .mosi(mosi), .select_n(select_n), .miso(miso_line)
  );

  function automatic logic [31:0] drv();
    return {24'h0000_00, pump_on, drive_out_g, drive_out_f, drive_out_e,
            drive_out_d, drive_out_c, drive_out_b, drive_out_a};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Frame plus commit latency, then the read-back word is compared
  task automatic frame(input int n, input logic [31:0] tx,
                       input logic [31:0] exp_rx);
    logic [31:0] rx;
    host.xfer(n, tx, rx);
    wait_clk(8);
    chk(rx, exp_rx);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    logic [15:0] w;
    logic [15:0] prev;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_clk(4);
    chk(32'(state_view), 32'h00);
    chk(32'(ctrl_view), 32'h00);
    chk(drv(), 32'h00);
    chk({30'h0, miso_oe, fault_line}, 32'h1);
    frame(16, 32'h8255, 32'h0000);
    chk(32'(state_view), 32'h55);
    chk(32'(ctrl_view), 32'h02);
    chk(drv(), 32'hD5);
    // Read-only frame returns the last word and commits nothing
    frame(16, 32'h002A, 32'h8255);
    chk(drv(), 32'hD5);
    prev = 16'h002A;
    for (int i = 0; i < 7; i++)
    begin
      w = 16'h8200 | (16'h0001 << i);
      frame(16, 32'(w), 32'(prev));
      chk(drv(), 32'h80 | (32'h1 << i));
      chk(32'(drive_out_a), 32'(i == 0));
      prev = w;
    end
    // Two-device chain: first word passes through, last one is kept
    frame(32, {16'h8013, 16'h827F}, {prev, 16'h8013});
    chk(32'(state_view), 32'h7F);
    @(posedge clk);
    iface_sel <= 1'b1;
    spread_pin <= 1'b1;
    frame(16, 32'h8200, 32'h0000);
    chk(drv(), 32'hFF);
    chk(32'(spread_enable), 32'h0);
    @(posedge clk);
    iface_sel <= 1'b0;
    wait_clk(6);
    chk(32'(spread_enable), 32'h1);
    // The refused frame was still shifted in, so it comes back now
    frame(16, 32'hAA7F, 32'h8200);
    chk({30'h0, sleep_on, pump_monitor_off}, 32'h3);
    // Fault with shutdown enabled
    @(posedge clk);
    fault_detect <= 1'b1;
    wait_clk(8);
    chk({30'h0, fault_line, ctrl_view.fault_latched}, 32'h1);
    chk(drv(), 32'h00);
    @(posedge clk);
    fault_detect <= 1'b0;
    wait_clk(8);
    chk({30'h0, fault_line, ctrl_view.fault_latched}, 32'h3);
    chk(drv(), 32'h00);
    frame(16, 32'h807F, 32'hAA7F);
    chk(32'(ctrl_view), 32'h00);
    frame(16, 32'h927F, 32'h807F);
    chk(drv(), 32'hFF);
    // Fault in report-only mode leaves the switches alone
    @(posedge clk);
    fault_detect <= 1'b1;
    wait_clk(8);
    chk(drv(), 32'hFF);
    chk(32'(ctrl_view.fault_latched), 32'h1);
    @(posedge clk);
    fault_detect <= 1'b0;
    wait_clk(4);
    end_of_test();
  end
endmodule // spi_switch_state_control_tb
